// file: external_bus_address_decoder.sv
module external_bus_address_decoder import ext_bus_pkg::*; #(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF,
    parameter int HOLD_CYCLES = HOLD_CYCLES_DEF
) (
    // Clock, reset, button
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic buttonN,
    // Controller bus
    input wire logic [7:0] ctrlAdIn,
    input wire logic ctrlAle,
    input wire logic [7:0] ctrlUpper,
    input wire logic ctrlWrN,
    input wire logic ctrlRdN,
    input wire logic [7:0] ctrlSpareIn,
    output logic [7:0] ctrlRdData,
    // Memory side
    output logic [15:0] memAddr,
    output logic romEnN,
    output logic ramEnN,
    output logic memWrN,
    output logic memRdN,
    output logic [7:0] memDataOut,
    output logic memDataOeN,
    input wire logic [7:0] memDataIn,
    // Expansion connector
    output logic periphSelectZeroN,
    output logic periphSelectOneN,
    output logic periphSelectTwoN,
    output logic periphSelectThreeN,
    output logic [3:0] lowBusLines,
    output logic [7:0] connectorDataLines,
    output logic connectorDataOeN,
    input wire logic [7:0] connectorDataIn,
    output logic connRdN,
    output logic connWrN,
    output logic [7:0] spareIoPort,
    // Serial link
    input wire logic rxd,
    output logic txd,
    // Boot status
    output logic bootDone,
    output logic ramTestFail
);
    boot_state_type state;
    logic sysRstN;
    logic [7:0] lowAddr;
    logic [15:0] busAddr;
    logic busWrN;
    logic busRdN;
    logic [7:0] busWrData;
    logic [15:0] seqAddr;
    logic seqWrN;
    logic seqRdN;
    logic [7:0] seqWrData;
    logic [15:0] ramTop;
    logic [1:0] phase;
    logic [1:0] patIdx;
    logic [3:0] bannerIdx;
    logic passFail;
    logic txStart;
    logic [7:0] txByte;
    logic txBusy;
    logic rxValid;
    logic [3:0] selN;
    logic romHit;
    logic ramHit;
    logic periphHit;

    function automatic logic [7:0] patternOf(input logic [1:0] idx);
        case (idx)
            2'h0: patternOf = 8'h00;
            2'h1: patternOf = 8'hff;
            2'h2: patternOf = 8'h55;
            default: patternOf = 8'haa;
        endcase
    endfunction

    function automatic logic [7:0] bannerOf(input logic [3:0] idx, input logic [15:0] top);
        case (idx)
            4'h0: bannerOf = 8'h55;
            4'h1: bannerOf = 8'h43;
            4'h2: bannerOf = 8'h4d;
            4'h3: bannerOf = FW_REV;
            4'h4: bannerOf = RAM_FIRST[15:8];
            4'h5: bannerOf = RAM_FIRST[7:0];
            4'h6: bannerOf = top[15:8];
            4'h7: bannerOf = top[7:0];
            default: bannerOf = END_BYTE;
        endcase
    endfunction

    reset_supervisor #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_supervisor (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .buttonN(buttonN),
        .sysRstN(sysRstN)
    );

    uart_link #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_uart (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .txStart(txStart),
        .txByte(txByte),
        .txBusy(txBusy),
        .txd(txd),
        .rxd(rxd),
        .rxValid(rxValid),
        .rxByte()
    );

    // Low address byte captured while the latch strobe is high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lowAddr <= '0;
        end else if (ctrlAle) begin
            lowAddr <= ctrlAdIn;
        end
    end

    // Boot logic owns the bus until it has finished
    always_comb begin
        if (bootDone) begin
            busAddr = {ctrlUpper, lowAddr};
            busWrN = ctrlWrN;
            busRdN = ctrlRdN;
            busWrData = ctrlAdIn;
        end else begin
            busAddr = seqAddr;
            busWrN = seqWrN;
            busRdN = seqRdN;
            busWrData = seqWrData;
        end
    end

    assign romHit = (busAddr <= ROM_LAST);
    assign ramHit = (busAddr >= RAM_FIRST) && (busAddr <= RAM_LAST);
    assign periphHit = (busAddr >= PERIPH_FIRST);

    // Address ranges are disjoint, so one enable at most is low
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            romEnN <= 1'b1;
            ramEnN <= 1'b1;
            selN <= '1;
        end else begin
            romEnN <= !romHit;
            ramEnN <= !ramHit;
            for (int i = 0; i < PERIPH_COUNT; i++) begin
                selN[i] <= !(periphHit &&
                    busAddr[WINDOW_MSB:WINDOW_LSB] == 2'(i));
            end
        end
    end

    assign periphSelectZeroN = selN[0];
    assign periphSelectOneN = selN[1];
    assign periphSelectTwoN = selN[2];
    assign periphSelectThreeN = selN[3];

    // Address, strobes and data toward memory and connector
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            memAddr <= '0;
            memWrN <= 1'b1;
            memRdN <= 1'b1;
            memDataOut <= '0;
            memDataOeN <= 1'b1;
            lowBusLines <= '0;
            connectorDataLines <= '0;
            connectorDataOeN <= 1'b1;
            connRdN <= 1'b1;
            connWrN <= 1'b1;
        end else begin
            memAddr <= busAddr;
            memWrN <= busWrN;
            memRdN <= busRdN;
            memDataOut <= busWrData;
            memDataOeN <= !(!busWrN && ramHit);
            lowBusLines <= busAddr[LOW_LINES-1:0];
            connectorDataLines <= busWrData;
            connectorDataOeN <= busWrN;
            connRdN <= busRdN;
            connWrN <= busWrN;
        end
    end

    // Read data back to the controller
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrlRdData <= '0;
        end else if (!connRdN) begin
            ctrlRdData <= (selN != '1) ? connectorDataIn : memDataIn;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            spareIoPort <= '0;
        end else begin
            spareIoPort <= ctrlSpareIn;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bootDone <= 1'b0;
        end else begin
            bootDone <= (state == BOOT_DONE);
        end
    end

    // Boot sequence, restarted by supervisor reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= BOOT_INIT;
            seqAddr <= RAM_FIRST;
            seqWrN <= 1'b1;
            seqRdN <= 1'b1;
            seqWrData <= '0;
            ramTop <= RAM_FIRST;
            phase <= '0;
            patIdx <= '0;
            bannerIdx <= '0;
            passFail <= 1'b0;
            txStart <= 1'b0;
            txByte <= '0;
            ramTestFail <= 1'b0;
        end else if (!sysRstN) begin
            state <= BOOT_INIT;
            seqAddr <= RAM_FIRST;
            seqWrN <= 1'b1;
            seqRdN <= 1'b1;
            phase <= '0;
            txStart <= 1'b0;
            ramTestFail <= 1'b0;
        end else begin
            txStart <= 1'b0;
            case (state)
                BOOT_INIT: begin
                    seqAddr <= RAM_FIRST;
                    ramTop <= RAM_FIRST;
                    phase <= '0;
                    state <= BOOT_SIZE;
                end
                BOOT_SIZE: begin
                    phase <= phase + 2'h1;
                    seqWrData <= PROBE_BYTE;
                    seqWrN <= (phase != '0);
                    seqRdN <= !(phase == ACC_WRITE_LAST || phase == ACC_LAST - 2'h1);
                    if (phase == ACC_LAST) begin
                        seqRdN <= 1'b1;
                        if (memDataIn == PROBE_BYTE) begin
                            ramTop <= seqAddr + SIZE_STEP - 16'h0001;
                            if (seqAddr == RAM_LAST - SIZE_STEP + 16'h0001) begin
                                state <= BOOT_LISTEN;
                            end else begin
                                seqAddr <= seqAddr + SIZE_STEP;
                            end
                        end else begin
                            state <= BOOT_LISTEN;
                        end
                    end
                end
                BOOT_LISTEN: begin
                    bannerIdx <= '0;
                    if (rxValid) begin
                        state <= BOOT_BANNER;
                    end
                end
                BOOT_BANNER: begin
                    if (!txBusy && !txStart) begin
                        txStart <= 1'b1;
                        txByte <= bannerOf(bannerIdx, ramTop);
                        bannerIdx <= bannerIdx + 4'h1;
                        if (bannerIdx == BANNER_LAST) begin
                            state <= BOOT_TEST_WR;
                            seqAddr <= RAM_FIRST;
                            patIdx <= '0;
                            passFail <= 1'b0;
                            phase <= '0;
                        end
                    end
                end
                BOOT_TEST_WR: begin
                    seqWrData <= patternOf(patIdx);
                    seqWrN <= (phase != '0);
                    phase <= (phase == ACC_WRITE_LAST) ? 2'h0 : phase + 2'h1;
                    if (phase == ACC_WRITE_LAST) begin
                        if (seqAddr == ramTop) begin
                            seqAddr <= RAM_FIRST;
                            state <= BOOT_TEST_RD;
                        end else begin
                            seqAddr <= seqAddr + 16'h0001;
                        end
                    end
                end
                BOOT_TEST_RD: begin
                    seqRdN <= (phase > ACC_READ_WAIT);
                    phase <= (phase == ACC_LAST - 2'h1) ? 2'h0 : phase + 2'h1;
                    if (phase == ACC_LAST - 2'h1) begin
                        if (memDataIn != patternOf(patIdx)) begin
                            passFail <= 1'b1;
                        end
                        if (seqAddr == ramTop) begin
                            state <= BOOT_REPORT;
                        end else begin
                            seqAddr <= seqAddr + 16'h0001;
                        end
                    end
                end
                BOOT_REPORT: begin
                    seqRdN <= 1'b1;
                    if (!txBusy && !txStart) begin
                        txStart <= 1'b1;
                        txByte <= passFail ? FAIL_BYTE : PASS_BYTE;
                        ramTestFail <= ramTestFail | passFail;
                        passFail <= 1'b0;
                        seqAddr <= RAM_FIRST;
                        phase <= '0;
                        if (patIdx == PATTERN_LAST) begin
                            state <= BOOT_DONE;
                        end else begin
                            patIdx <= patIdx + 2'h1;
                            state <= BOOT_TEST_WR;
                        end
                    end
                end
                BOOT_DONE: begin
                    seqWrN <= 1'b1;
                    seqRdN <= 1'b1;
                end
                default: begin
                    state <= BOOT_INIT;
                end
            endcase
        end
    end
endmodule // external_bus_address_decoder

// file: ext_bus_pkg.sv
package ext_bus_pkg;
    // Address map
    localparam logic [15:0] ROM_LAST = 16'h3fff;
    localparam logic [15:0] RAM_FIRST = 16'h4000;
    localparam logic [15:0] RAM_LAST = 16'hbfff;
    localparam logic [15:0] PERIPH_FIRST = 16'hc000;
    localparam logic [15:0] SIZE_STEP = 16'h1000;
    localparam int WINDOW_MSB = 13;
    localparam int WINDOW_LSB = 12;
    localparam int LOW_LINES = 4;
    localparam int PERIPH_COUNT = 4;

    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int BAUD_RATE = 1200;
    localparam int BIT_CYCLES_DEF = CLK_HZ / BAUD_RATE;
    localparam int RESET_HOLD_US = 1000;
    localparam int HOLD_CYCLES_DEF = (CLK_HZ / 1_000_000) * RESET_HOLD_US;
    localparam logic [1:0] ACC_LAST = 2'h3;
    localparam logic [1:0] ACC_WRITE_LAST = 2'h1;
    localparam logic [1:0] ACC_READ_WAIT = 2'h1;

    // Boot sequencer data
    localparam logic [7:0] PROBE_BYTE = 8'ha5;
    localparam logic [7:0] FW_REV = 8'h01; // Arbitrary revision value
    localparam logic [7:0] PASS_BYTE = 8'h50;
    localparam logic [7:0] FAIL_BYTE = 8'h46;
    localparam logic [7:0] END_BYTE = 8'h0d;
    localparam logic [3:0] BANNER_LAST = 4'h8;
    localparam logic [1:0] PATTERN_LAST = 2'h3;

    typedef enum logic [3:0] {
        BOOT_INIT,
        BOOT_SIZE,
        BOOT_LISTEN,
        BOOT_BANNER,
        BOOT_TEST_WR,
        BOOT_TEST_RD,
        BOOT_REPORT,
        BOOT_DONE
    } boot_state_type;
endpackage

// file: reset_supervisor.sv
module reset_supervisor import ext_bus_pkg::*; #(
    parameter int HOLD_CYCLES = HOLD_CYCLES_DEF
) (
    // Clock and power-on reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Manual button, low while pressed
    input wire logic buttonN,
    // Reset to the boot logic
    output logic sysRstN
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);
    localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);

    logic [CW-1:0] holdCount;

    // Power-up and every press start a fresh hold; no watchdog source exists
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            holdCount <= '0;
            sysRstN <= 1'b0;
        end else if (!buttonN) begin
            holdCount <= '0;
            sysRstN <= 1'b0;
        end else if (holdCount == HOLD_LAST) begin
            sysRstN <= 1'b1;
        end else begin
            holdCount <= holdCount + CW'(1);
        end
    end
endmodule // reset_supervisor

// file: uart_link.sv
module uart_link import ext_bus_pkg::*; #(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Transmit side
    input wire logic txStart,
    input wire logic [7:0] txByte,
    output logic txBusy,
    output logic txd,
    // Receive side
    input wire logic rxd,
    output logic rxValid,
    output logic [7:0] rxByte
);
    localparam int CW = $clog2(BIT_CYCLES + 1);
    localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
    localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYCLES / 2);
    localparam logic [3:0] FRAME_LAST = 4'h9;

    logic [CW-1:0] txDiv;
    logic [3:0] txCount;
    logic [9:0] txShift;
    logic [CW-1:0] rxDiv;
    logic [3:0] rxCount;
    logic [8:0] rxShift;
    logic rxActive;
    logic txTick;

    assign txTick = (txDiv == BIT_LAST);

    // Bit-rate enable for the transmitter
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            txDiv <= '0;
        end else if (!txBusy || txTick) begin
            txDiv <= '0;
        end else begin
            txDiv <= txDiv + CW'(1);
        end
    end

    // Start bit, eight data bits LSB first, stop bit
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            txBusy <= 1'b0;
            txShift <= '1;
            txCount <= '0;
            txd <= 1'b1;
        end else if (!txBusy) begin
            if (txStart) begin
                txBusy <= 1'b1;
                txShift <= {1'b1, txByte, 1'b0};
                txCount <= '0;
                txd <= 1'b0;
            end
        end else if (txTick) begin
            if (txCount == FRAME_LAST) begin
                txBusy <= 1'b0;
                txd <= 1'b1;
            end else begin
                txShift <= {1'b1, txShift[9:1]};
                txd <= txShift[1];
                txCount <= txCount + 4'h1;
            end
        end
    end

    // Receiver samples mid-bit after a falling start edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rxActive <= 1'b0;
            rxDiv <= '0;
            rxCount <= '0;
            rxShift <= '0;
            rxValid <= 1'b0;
            rxByte <= '0;
        end else begin
            rxValid <= 1'b0;
            if (!rxActive) begin
                if (!rxd) begin
                    rxActive <= 1'b1;
                    rxDiv <= BIT_LAST - HALF_LAST;
                    rxCount <= '0;
                end
            end else if (rxDiv == BIT_LAST) begin
                rxDiv <= '0;
                rxShift <= {rxd, rxShift[8:1]};
                rxCount <= rxCount + 4'h1;
                if (rxCount == 4'h0 && rxd) begin
                    rxActive <= 1'b0;
                end else if (rxCount == FRAME_LAST) begin
                    rxActive <= 1'b0;
                    rxValid <= rxd;
                    rxByte <= rxShift[8:1];
                end
            end else begin
                rxDiv <= rxDiv + CW'(1);
            end
        end
    end
endmodule // uart_link

// file: external_bus_address_decoder_monitor.sv
module external_bus_address_decoder_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic buttonN,
    // Controller bus
    input wire logic [7:0] ctrlAdIn,
    input wire logic ctrlAle,
    input wire logic [7:0] ctrlUpper,
    input wire logic ctrlWrN,
    input wire logic ctrlRdN,
    input wire logic [7:0] ctrlSpareIn,
    // Memory and connector
    input wire logic [15:0] memAddr,
    input wire logic romEnN,
    input wire logic ramEnN,
    input wire logic periphSelectZeroN,
    input wire logic periphSelectOneN,
    input wire logic periphSelectTwoN,
    input wire logic periphSelectThreeN,
    input wire logic [7:0] connectorDataLines,
    input wire logic connRdN,
    input wire logic connWrN,
    input wire logic [7:0] spareIoPort,
    input wire logic bootDone
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ownCnt;
    logic [2:0] btnHigh;
    logic owned;
    logic [3:0] selN;
    assign owned = bootDone && ownCnt == 2'h3;
    assign selN = {periphSelectZeroN, periphSelectOneN, periphSelectTwoN, periphSelectThreeN};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Cycles since the controller took the bus
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) ownCnt <= 2'h0;
        else if (!bootDone) ownCnt <= 2'h0;
        else if (ownCnt != 2'h3) ownCnt <= ownCnt + 2'h1;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) btnHigh <= 3'h0;
        else if (!buttonN) btnHigh <= 3'h0;
        else if (btnHigh != 3'h4) btnHigh <= btnHigh + 3'h1;
    end
    single_enable_a: assert property ($countones({romEnN, ramEnN, selN}) >= 5)
        else $error("more than one enable low");
    upper_direct_a: assert property (owned |-> memAddr[15:8] == $past(ctrlUpper))
        else $error("upper address wrong");
    low_latch_a: assert property (owned && $past(ctrlAle, 2) && !$past(ctrlAle)
        |-> memAddr[7:0] == $past(ctrlAdIn, 2)) else $error("low address not latched");
    mem_decode_a: assert property (owned |-> romEnN == ($past(ctrlUpper) > 8'h3f)
        && ramEnN == !($past(ctrlUpper) inside {[8'h40:8'hbf]})) else $error("memory decode");
    sel_decode_a: assert property (owned |-> selN == ~(4'h8 >> ($past(ctrlUpper[7:4]) - 4'hc)))
        else $error("select decode");
    strobe_follow_a: assert property (owned |-> connWrN == $past(ctrlWrN)
        && connRdN == $past(ctrlRdN)) else $error("strobe mismatch");
    write_data_a: assert property (owned && !$past(ctrlWrN)
        |-> connectorDataLines == $past(ctrlAdIn)) else $error("write data wrong");
    spare_copy_a: assert property (owned |-> spareIoPort == $past(ctrlSpareIn))
        else $error("spare port wrong");
    no_watchdog_a: assert property (bootDone && btnHigh == 3'h4 |=> bootDone)
        else $error("unexpected reset");
    button_reset_a: assert property ($fell(buttonN) |-> ##[1:8] !bootDone)
        else $error("button gave no reset");
    cover property ($rose(bootDone));
    cover property (owned && !periphSelectThreeN && !connRdN);
    cover property (owned && !ramEnN && !connWrN);
endmodule // external_bus_address_decoder_monitor

bind external_bus_address_decoder external_bus_address_decoder_monitor monitor (
    .sys_clk, .rstn, .buttonN, .ctrlAdIn, .ctrlAle, .ctrlUpper, .ctrlWrN, .ctrlRdN,
    .ctrlSpareIn, .memAddr, .romEnN, .ramEnN, .periphSelectZeroN, .periphSelectOneN,
    .periphSelectTwoN, .periphSelectThreeN, .connectorDataLines, .connRdN, .connWrN,
    .spareIoPort, .bootDone
);

// file: kit_side_model.sv
module kit_side_model import ext_bus_pkg::*; #(
    parameter int RAM_BLOCKS = 1
) (
    // Clock
    input wire logic sys_clk,
    // Memory port
    input wire logic [15:0] memAddr,
    input wire logic ramEnN,
    input wire logic memWrN,
    input wire logic [7:0] memDataOut,
    output logic [7:0] memDataIn,
    // Connector
    input wire logic periphSelectZeroN,
    input wire logic periphSelectOneN,
    input wire logic periphSelectTwoN,
    input wire logic periphSelectThreeN,
    input wire logic [3:0] lowBusLines,
    input wire logic connRdN,
    output logic [7:0] connectorDataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RAM_BYTES = RAM_BLOCKS * 4096;
    logic [7:0] mem [RAM_BYTES];
    logic [7:0] churn = 8'h00;
    logic [3:0] selN;
    logic fitted;
    assign selN = {periphSelectZeroN, periphSelectOneN, periphSelectTwoN, periphSelectThreeN};
    // Short RAM from 4000 up
    assign fitted = !ramEnN && memAddr >= RAM_FIRST && memAddr < RAM_FIRST + RAM_BYTES;
    always_ff @(posedge sys_clk) begin
        churn <= churn + 8'h02;
        if (fitted && !memWrN) mem[16'(memAddr - RAM_FIRST)] <= memDataOut;
    end
    // Floating lines never match the probe
    assign memDataIn = fitted ? mem[16'(memAddr - RAM_FIRST)] : churn;
    assign connectorDataIn = (selN != 4'hf && !connRdN) ? {selN, lowBusLines} : churn;
endmodule // kit_side_model

// file: test_external_bus_address_decoder.sv
module test_external_bus_address_decoder import ext_bus_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BITS = 16;
    localparam int HOLD = 8;
    localparam int BLOCKS = 1;
    localparam logic [15:0] RAM_TOP = 16'(RAM_FIRST + BLOCKS * SIZE_STEP - 1);
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic buttonN = 1'b1;
    logic ctrlAle = 1'b0;
    logic ctrlWrN = 1'b1;
    logic ctrlRdN = 1'b1;
    logic rxd = 1'b1;
    logic [7:0] ctrlAdIn = 8'h00;
    logic [7:0] ctrlUpper = 8'h00;
    logic [7:0] ctrlSpareIn = 8'h00;
    logic [7:0] ctrlRdData, memDataOut, memDataIn, connectorDataLines, connectorDataIn;
    logic [7:0] spareIoPort, rxb;
    logic [15:0] memAddr;
    logic [3:0] lowBusLines;
    logic romEnN, ramEnN, memWrN, memRdN, memDataOeN, connectorDataOeN, connRdN, connWrN;
    logic periphSelectZeroN, periphSelectOneN, periphSelectTwoN, periphSelectThreeN;
    logic txd, bootDone, ramTestFail;
    logic [5:0] enables;
    logic [7:0] shadow [logic [15:0]];
    logic [7:0] banner [9] = '{8'h55, 8'h43, 8'h4d, FW_REV, 8'h40, 8'h00, RAM_TOP[15:8],
        RAM_TOP[7:0], END_BYTE};
    logic [15:0] corner [13] = '{16'h0000, 16'h3fff, 16'h4000, RAM_TOP, 16'hbfff, 16'hc000,
        16'hcfff, 16'hd000, 16'hdfff, 16'he000, 16'hefff, 16'hf000, 16'hffff};
    int mismatches = 0;
    int testsRun = 0;
    int cycles = 0;
    assign enables = {romEnN, ramEnN, periphSelectZeroN, periphSelectOneN, periphSelectTwoN,
        periphSelectThreeN};

    always #12.5 sys_clk = ~sys_clk;

    external_bus_address_decoder #(.BIT_CYCLES(BITS), .HOLD_CYCLES(HOLD)) uut (
        .sys_clk, .rstn, .buttonN, .ctrlAdIn, .ctrlAle, .ctrlUpper, .ctrlWrN, .ctrlRdN,
        .ctrlSpareIn, .ctrlRdData, .memAddr, .romEnN, .ramEnN, .memWrN, .memRdN, .memDataOut,
        .memDataOeN, .memDataIn, .periphSelectZeroN, .periphSelectOneN, .periphSelectTwoN,
        .periphSelectThreeN, .lowBusLines, .connectorDataLines, .connectorDataOeN,
        .connectorDataIn, .connRdN, .connWrN, .spareIoPort, .rxd, .txd, .bootDone, .ramTestFail
    );
    kit_side_model #(.RAM_BLOCKS(BLOCKS)) kit (
        .sys_clk, .memAddr, .ramEnN, .memWrN, .memDataOut, .memDataIn, .periphSelectZeroN,
        .periphSelectOneN, .periphSelectTwoN, .periphSelectThreeN, .lowBusLines, .connRdN,
        .connectorDataIn
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        testsRun++;
        if (seen !== want) begin
            mismatches++;
            $display("Error at %0t ns: seen %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 99000) begin
            mismatches++;
            report_and_stop();
        end
    end

    function automatic logic [5:0] decode(input logic [15:0] a);
        logic [5:0] e;
        e = 6'h3f;
        if (a <= ROM_LAST) e[5] = 1'b0;
        else if (a <= RAM_LAST) e[4] = 1'b0;
        else e[3 - a[13:12]] = 1'b0;
        return e;
    endfunction

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd = f[i];
            repeat (i == 9 ? BITS / 4 : BITS) @(negedge sys_clk);
        end
    endtask

    task automatic get_byte(output logic [7:0] b);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 40000) begin
            @(negedge sys_clk);
            n++;
        end
        repeat (BITS / 2) @(negedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BITS) @(negedge sys_clk);
            b[i] = txd;
        end
        repeat (BITS) @(negedge sys_clk);
        check(txd, 1'b1);
    endtask

    // One controller cycle: address phase, then a read or a write
    task automatic bus(input logic [15:0] a, input logic wr);
        logic [7:0] wd, spare;
        logic [5:0] dec;
        wd = 8'($urandom);
        spare = 8'($urandom);
        dec = decode(a);
        ctrlAle = 1'b1;
        ctrlAdIn = a[7:0];
        ctrlSpareIn = spare;
        @(negedge sys_clk);
        ctrlAle = 1'b0;
        ctrlUpper = a[15:8];
        ctrlAdIn = wr ? wd : ~a[7:0];
        ctrlWrN = !wr;
        ctrlRdN = wr;
        @(negedge sys_clk);
        check(enables, dec);
        check(memAddr, a);
        check(lowBusLines, a[3:0]);
        check({connWrN, connRdN, memWrN, memRdN}, {2{!wr, wr}});
        check({memDataOeN, connectorDataOeN}, {dec[4] | !wr, !wr});
        check(spareIoPort, spare);
        if (wr) check(connectorDataLines, wd);
        @(negedge sys_clk);
        if (!wr && a >= PERIPH_FIRST) check(ctrlRdData, {dec[3:0], a[3:0]});
        else if (!wr && shadow.exists(a)) check(ctrlRdData, shadow[a]);
        if (wr && a >= RAM_FIRST && a <= RAM_TOP) shadow[a] = wd;
        ctrlWrN = 1'b1;
        ctrlRdN = 1'b1;
    endtask

    initial begin
        logic [15:0] a;
        int n;
        void'($urandom(32'ha00a));
        repeat (2) @(negedge sys_clk);
        check(enables, 6'h3f);
        check({txd, bootDone}, 2'b10);
        rstn = 1'b1;
        $display("Test reset done");
        repeat (2000) @(negedge sys_clk);
        check({txd, bootDone}, 2'b10);
        send_byte(8'($urandom));
        for (int i = 0; i < 9; i++) begin
            get_byte(rxb);
            check(rxb, banner[i]);
        end
        for (int i = 0; i < 4; i++) begin
            get_byte(rxb);
            check(rxb, PASS_BYTE);
        end
        n = 0;
        while (bootDone !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        check({bootDone, ramTestFail}, 2'b10);
        $display("Test boot done");
        foreach (corner[i]) begin
            bus(corner[i], 1'b1);
            bus(corner[i], 1'b0);
        end
        $display("Test boundaries done");
        repeat (300) begin
            a = ($urandom & 1) ? (RAM_FIRST | 16'($urandom & 32'h3f)) : 16'($urandom);
            bus(a, 1'($urandom));
        end
        $display("Test random done");
        repeat (3000) @(negedge sys_clk);
        check(bootDone, 1'b1);
        buttonN = 1'b0;
        repeat (8) @(negedge sys_clk);
        check(bootDone, 1'b0);
        buttonN = 1'b1;
        repeat (HOLD + 50) @(negedge sys_clk);
        check({txd, bootDone}, 2'b10);
        $display("Test button done");
        report_and_stop();
    end
endmodule // test_external_bus_address_decoder
